// ==== common/spd_consts.svh ====
`ifndef SPD_CONSTS_SVH
`define SPD_CONSTS_SVH

// ----------------------------------------------------------------------------
// clock rates and timing
// ----------------------------------------------------------------------------
`define SPD_CLK_PERIOD_NS  10
`define SPD_SUB_CLOCK_HZ   32768
`define SPD_CLK_HZ         100000000
// subsystem tick period, rounded down to whole system cycles
`define SPD_SUB_DIV_CYC    (`SPD_CLK_HZ / `SPD_SUB_CLOCK_HZ)
`define SPD_EDGE_DELAY_NS  15000
// least time: round up
`define SPD_EDGE_DELAY_CYC ((`SPD_EDGE_DELAY_NS + `SPD_CLK_PERIOD_NS - 1) / `SPD_CLK_PERIOD_NS)

// ----------------------------------------------------------------------------
// pulse width select codes and reset values
// ----------------------------------------------------------------------------
`define SPD_PW_HALF_TICK   2'h0
`define SPD_PW_32_TICKS    2'h1
`define SPD_PW_2_TICKS     2'h2
`define SPD_PW_1_TICK      2'h3
`define SPD_COUNT_RST      8'h00

`endif

// ==== common/spd_pkg.sv ====
package spd_pkg;

  typedef enum logic [1:0] {
    PH_LOW  = 2'b01,
    PH_HIGH = 2'b10
  } out_phase_t;

  typedef struct packed {
    logic [11:0] div_cnt;
    logic [7:0]  count;
    out_phase_t  phase;
    logic [17:0] width_cnt;
    logic        clk_a;
    logic        clk_b;
    logic [1:0]  sync_a;
    logic [1:0]  sync_b;
    logic        shaped_a;
    logic        shaped_b;
    logic        shaped_valid;
    logic        delay_busy;
    logic [10:0] delay_cnt;
    logic        pend_a;
    logic        pend_b;
    logic        match_irq;
    logic        edge_irq;
    logic        level_a;
    logic        level_b;
    logic        phase_flag;
  } state_t;

endpackage : spd_pkg

// ==== verification/sampling_phase_detector_tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module sampling_phase_detector_tb_top;
  localparam int unsigned SUB_DIV    = 8;
  localparam int unsigned EDGE_DELAY = 5;
  typedef struct packed { logic a; logic b; logic [2:0] flags; } row_t;
  logic       clk, rst, run, mode, want_a, want_b, pin_a, pin_b;
  logic       out_a, out_b, m_irq, e_irq, lv_a, lv_b, ph, prev;
  logic [7:0] cmp, cnt_v;
  logic [1:0] sel;
  int         errors, checked, n, d, seen, i;
  row_t       rows [4] = '{'{1'b1, 1'b1, 3'h6}, '{1'b0, 1'b0, 3'h0}, '{1'b0, 1'b1, 3'h3},
                           '{1'b1, 1'b0, 3'h5}};
  int         widths [4] = '{SUB_DIV / 2, 32 * SUB_DIV, 2 * SUB_DIV, SUB_DIV};
  sampling_phase_detector #(.SUB_DIV(SUB_DIV), .EDGE_DELAY(EDGE_DELAY)) u_sampling_phase_detector (
    .CLK(clk), .SYS_RST(rst), .COUNT_RUN_FLAG(run), .MODE_SELECT_BIT(mode),
    .PERIOD_COMPARE(cmp), .PULSE_WIDTH_SEL(sel), .OUT_ENABLE_A(1'b1), .OUT_ENABLE_B(1'b1),
    .SENSOR_IN_A(pin_a), .SENSOR_IN_B(pin_b), .SAMPLE_CLOCK_OUT_A(out_a),
    .SAMPLE_CLOCK_OUT_B(out_b), .MATCH_IRQ(m_irq), .EDGE_IRQ(e_irq), .LEVEL_A_FLAG(lv_a),
    .LEVEL_B_FLAG(lv_b), .PHASE_FLAG(ph), .COUNT_VALUE(cnt_v));
  spd_sensor_model u_spd_sensor_model (.clk_out(out_a), .want_a(want_a), .want_b(want_b),
    .pin_a(pin_a), .pin_b(pin_b));
  // ----
  // helpers
  // ----
  task automatic wrap_up();
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  task automatic step();
    @(posedge clk);
    #1;
  endtask : step
  // every open-ended wait goes through here so a hang always ends in the report
  task automatic tick();
    step();
    n++;
    if (n > 4000) begin
      errors++;
      wrap_up();
    end
  endtask : tick
  task automatic wait_match();
    n = 0;
    while (m_irq !== 1'b1) tick();
  endtask : wait_match
  task automatic idle(input int c);
    seen = 0;
    repeat (c) begin
      step();
      seen += int'(e_irq !== 1'b0);
    end
  endtask : idle
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    rst = 1'b1;
    run = 1'b0;
    mode = 1'b0;
    want_a = 1'b0;
    want_b = 1'b0;
    cmp = 8'h03;
    sel = 2'h3;
    errors = 0;
    checked = 0;
    repeat (12) step();
    rst = 1'b0;
    step();
    chk({2'h0, out_a, m_irq, e_irq, lv_a, lv_b, ph, cnt_v}, 16'h0000);
    run = 1'b1;
    wait_match();
    chk({14'h0, out_a, out_b}, 16'h0003);
    step();
    wait_match();
    chk(16'(n + 1), 16'(4 * SUB_DIV));
    chk({14'h0, out_a, out_b}, 16'h0000);
    run = 1'b0;
    step();
    mode = 1'b1;
    cmp = 8'h40;
    for (i = 0; i < 4; i++) begin
      sel = 2'(i);
      run = 1'b1;
      wait_match();
      chk({14'h0, out_a, out_b}, 16'h0003);
      n = 0;
      while (out_a === 1'b1) tick();
      chk(16'(n), 16'(widths[i]));
      run = 1'b0;
      step();
    end
    run = 1'b1;
    for (i = 0; i < 4; i++) begin
      want_a = rows[i].a;
      idle(1100);
      chk(16'(seen), 16'h0000);
      want_b = rows[i].b;
      n = 0;
      d = 0;
      while (e_irq !== 1'b1) begin
        prev = out_a;
        tick();
        d = (prev && !out_a) ? 0 : d + 1;
      end
      chk(16'(d), 16'(EDGE_DELAY));
      chk({13'h0, lv_a, lv_b, ph}, {13'h0, rows[i].flags});
    end
    run = 1'b0;
    step();
    mode = 1'b0;
    step();
    step();
    chk({13'h0, lv_a, lv_b, ph}, 16'h0000);
    run = 1'b1;
    want_b = 1'b1;
    idle(1400);
    chk(16'(seen), 16'h0000);
    wrap_up();
  end
endmodule : sampling_phase_detector_tb_top
`default_nettype wire

// ==== verification/spd_props.sv ====
`timescale 1ns/100ps
`default_nettype none
module spd_props #(
  parameter int unsigned SUB_DIV    = 8,
  parameter int unsigned EDGE_DELAY = 5
) (
  input wire logic       CLK,                // clock
  input wire logic       SYS_RST,            // reset
  input wire logic       MODE_SELECT_BIT,    // mode
  input wire logic       SAMPLE_CLOCK_OUT_A, // pin a
  input wire logic       MATCH_IRQ,          // match pulse
  input wire logic       EDGE_IRQ,           // edge pulse
  input wire logic       LEVEL_A_FLAG,       // level a
  input wire logic       LEVEL_B_FLAG,       // level b
  input wire logic       PHASE_FLAG,         // phase
  input wire logic [7:0] COUNT_VALUE         // count
);
  wire logic [2:0] flags = {LEVEL_A_FLAG, LEVEL_B_FLAG, PHASE_FLAG};
  default clocking dcb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  AST_MATCH_PULSE: assert property (MATCH_IRQ |=> !MATCH_IRQ)
    else $error("match pulse too long");
  AST_EDGE_PULSE: assert property (EDGE_IRQ |=> !EDGE_IRQ)
    else $error("edge pulse too long");
  AST_MATCH_CLEAR: assert property (MATCH_IRQ |-> COUNT_VALUE == 8'h00)
    else $error("count not cleared at match");
  AST_TIMER_QUIET: assert property (
    !MODE_SELECT_BIT && !$past(MODE_SELECT_BIT) |-> !EDGE_IRQ)
    else $error("edge pulse in timer mode");
  AST_TIMER_FLAGS: assert property (!MODE_SELECT_BIT |=> flags == 3'h0)
    else $error("flags not zero in timer mode");
  AST_FLAGS_HOLD: assert property (
    MODE_SELECT_BIT && $past(MODE_SELECT_BIT) && !EDGE_IRQ |-> $stable(flags))
    else $error("flags moved without edge pulse");
  AST_PHASE_XOR: assert property (EDGE_IRQ |-> PHASE_FLAG == (LEVEL_A_FLAG ^ LEVEL_B_FLAG))
    else $error("phase flag wrong");
  AST_TIMER_TOGGLE: assert property (
    !MODE_SELECT_BIT && !$past(MODE_SELECT_BIT) && MATCH_IRQ
    |-> SAMPLE_CLOCK_OUT_A != $past(SAMPLE_CLOCK_OUT_A))
    else $error("no toggle at match");
  AST_SAMPLE_RISE: assert property (
    MODE_SELECT_BIT && $past(MODE_SELECT_BIT) && MATCH_IRQ |-> SAMPLE_CLOCK_OUT_A)
    else $error("no sampling pulse at match");
  cover property (EDGE_IRQ && PHASE_FLAG);
  cover property (EDGE_IRQ && !PHASE_FLAG);
  cover property (MATCH_IRQ && MODE_SELECT_BIT);
endmodule : spd_props
bind sampling_phase_detector spd_props #(.SUB_DIV(SUB_DIV), .EDGE_DELAY(EDGE_DELAY)) u_spd_props (
  .CLK(CLK), .SYS_RST(SYS_RST), .MODE_SELECT_BIT(MODE_SELECT_BIT),
  .SAMPLE_CLOCK_OUT_A(SAMPLE_CLOCK_OUT_A), .MATCH_IRQ(MATCH_IRQ), .EDGE_IRQ(EDGE_IRQ),
  .LEVEL_A_FLAG(LEVEL_A_FLAG), .LEVEL_B_FLAG(LEVEL_B_FLAG), .PHASE_FLAG(PHASE_FLAG),
  .COUNT_VALUE(COUNT_VALUE));
`default_nettype wire

// ==== verification/spd_sensor_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module spd_sensor_model (
  input  wire logic clk_out, // sampling clock from the block
  input  wire logic want_a,  // level asked for on a
  input  wire logic want_b,  // level asked for on b
  output var logic  pin_a,   // sensor pin a
  output var logic  pin_b    // sensor pin b
);
  // change on the rise so the level has settled long before the capturing fall
  initial {pin_a, pin_b} = 2'h0;
  always @(posedge clk_out) {pin_a, pin_b} <= {want_a, want_b};
endmodule : spd_sensor_model
`default_nettype wire

// ==== verilog/sampling_phase_detector.sv ====
// Operation
// - sampling mode runs 8-bit interval counter, cleared when count equals compare value.
// - output period from compare match; pulse width from select field bits 0 and 1.
// - both sensor inputs captured on each falling edge of sampling clock.
// - edge interrupt on every rising and falling edge of shaped input b.
// - edge interrupt and all flag updates occur 15 us after the shaped edge.
// - level b flag takes shaped input b level at edge interrupt.
// - shaped input a sampled at b edges, moved to level a flag at interrupt.
// - phase flag clear when a matches b edge direction, set when inverted.
// - phase detector idle in plain timer mode: no edge interrupts or updates.
// - edge interrupt, both level flags and phase flag update in one cycle.
// - level a flag may be undefined when both inputs change together.
// - mode select 0 picks plain timer mode, 1 picks sampling mode.
// - plain timer mode toggles both sampling outputs on each compare match.
// - level flags and phase flag held at zero in plain timer mode.
`timescale 1ns/100ps
`default_nettype none
`include "spd_consts.svh"

module sampling_phase_detector #(
  parameter int unsigned SUB_DIV     = `SPD_SUB_DIV_CYC,
  parameter int unsigned EDGE_DELAY  = `SPD_EDGE_DELAY_CYC
) (
  input  wire logic       CLK,              // system clock, 100 MHz
  input  wire logic       SYS_RST,          // synchronous reset, active high
  input  wire logic       COUNT_RUN_FLAG,   // counter runs while high
  input  wire logic       MODE_SELECT_BIT,  // 0 plain timer, 1 sampling output
  input  wire logic [7:0] PERIOD_COMPARE,   // compare value for the counter
  input  wire logic [1:0] PULSE_WIDTH_SEL,  // {hi, lo} pulse width select
  input  wire logic       OUT_ENABLE_A,     // enables sampling clock a pin
  input  wire logic       OUT_ENABLE_B,     // enables sampling clock b pin
  input  wire logic       SENSOR_IN_A,      // sensor pin a, asynchronous
  input  wire logic       SENSOR_IN_B,      // sensor pin b, asynchronous
  output logic            SAMPLE_CLOCK_OUT_A, // sampling clock pin a
  output logic            SAMPLE_CLOCK_OUT_B, // sampling clock pin b
  output logic            MATCH_IRQ,        // compare match pulse
  output logic            EDGE_IRQ,         // delayed edge pulse
  output logic            LEVEL_A_FLAG,     // level of shaped a at b edge
  output logic            LEVEL_B_FLAG,     // level of shaped b at edge
  output logic            PHASE_FLAG,       // 1 when inverted phase
  output logic [7:0]      COUNT_VALUE       // current counter value
);

  // --------------------------------------------------------------------------
  // pulse widths in system cycles
  // --------------------------------------------------------------------------
  localparam logic [17:0] PW_HALF = 18'(SUB_DIV / 2);
  localparam logic [17:0] PW_ONE  = 18'(SUB_DIV);
  localparam logic [17:0] PW_TWO  = 18'(2 * SUB_DIV);
  localparam logic [17:0] PW_32   = 18'(32 * SUB_DIV);
  localparam logic [11:0] DIV_LAST   = 12'(SUB_DIV - 1);
  localparam logic [10:0] DELAY_LAST = 11'(EDGE_DELAY - 1);

  spd_pkg::state_t s_q;
  spd_pkg::state_t s_d;

  logic [17:0] width_load;
  logic        tick;
  logic        match;
  logic        sample_mode;
  logic        fall;
  logic        new_a;
  logic        new_b;

  // --------------------------------------------------------------------------
  // width select decode
  // --------------------------------------------------------------------------
  always_comb begin
    case (PULSE_WIDTH_SEL)
      `SPD_PW_HALF_TICK: width_load = PW_HALF;
      `SPD_PW_32_TICKS:  width_load = PW_32;
      `SPD_PW_2_TICKS:   width_load = PW_TWO;
      default:           width_load = PW_ONE;
    endcase
  end

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.match_irq = 1'b0;
    s_d.edge_irq  = 1'b0;
    sample_mode = MODE_SELECT_BIT;
    fall  = 1'b0;
    new_a = s_q.shaped_a;
    new_b = s_q.shaped_b;
    // ------------------------------------------------------------------------
    // sensor synchroniser: pins pass two flip-flops before any use
    // ------------------------------------------------------------------------
    s_d.sync_a = {s_q.sync_a[0], SENSOR_IN_A};
    s_d.sync_b = {s_q.sync_b[0], SENSOR_IN_B};

    // ------------------------------------------------------------------------
    // subsystem rate as an enable pulse from a divider
    // ------------------------------------------------------------------------
    tick = 1'b0;
    if (!COUNT_RUN_FLAG) begin
      s_d.div_cnt = 12'h000;
    end else if (s_q.div_cnt == DIV_LAST) begin
      s_d.div_cnt = 12'h000;
      tick = 1'b1;
    end else begin
      s_d.div_cnt = s_q.div_cnt + 12'h001;
    end

    // ------------------------------------------------------------------------
    // interval counter
    // ------------------------------------------------------------------------
    match = 1'b0;
    if (tick) begin
      if (s_q.count == PERIOD_COMPARE) begin
        match = 1'b1;
        s_d.count = `SPD_COUNT_RST;
        s_d.match_irq = 1'b1;
      end else begin
        s_d.count = s_q.count + 8'h01;
      end
    end

    // ------------------------------------------------------------------------
    // sampling clock generation
    // ------------------------------------------------------------------------
    if (!sample_mode) begin
      s_d.phase = spd_pkg::PH_LOW;
      if (match) begin
        s_d.clk_a = ~s_q.clk_a;
        s_d.clk_b = ~s_q.clk_b;
      end
    end else begin
      case (s_q.phase)
        spd_pkg::PH_LOW: begin
          if (match) begin
            s_d.phase = spd_pkg::PH_HIGH;
            s_d.width_cnt = width_load;
          end
        end
        spd_pkg::PH_HIGH: begin
          // a stopped counter still finishes the pulse, so no clock is left high
          if (s_q.width_cnt <= 18'h00001) begin
            s_d.phase = spd_pkg::PH_LOW;
            fall = 1'b1;
          end else begin
            s_d.width_cnt = s_q.width_cnt - 18'h00001;
          end
        end
        default: s_d.phase = spd_pkg::PH_LOW;
      endcase
      s_d.clk_a = (s_d.phase == spd_pkg::PH_HIGH) && OUT_ENABLE_A;
      s_d.clk_b = (s_d.phase == spd_pkg::PH_HIGH) && OUT_ENABLE_B;
    end
    if (!OUT_ENABLE_A) begin
      s_d.clk_a = 1'b0;
    end
    if (!OUT_ENABLE_B) begin
      s_d.clk_b = 1'b0;
    end

    // ------------------------------------------------------------------------
    // phase detector
    // ------------------------------------------------------------------------
    if (!sample_mode) begin
      s_d.shaped_valid = 1'b0;
      s_d.delay_busy   = 1'b0;
      s_d.level_a      = 1'b0;
      s_d.level_b      = 1'b0;
      s_d.phase_flag   = 1'b0;
    end else begin
      if (fall) begin
        new_a = s_q.sync_a[1];
        new_b = s_q.sync_b[1];
        s_d.shaped_a = new_a;
        s_d.shaped_b = new_b;
        s_d.shaped_valid = 1'b1;
      end
      // the first capture only seeds the shaper, it is not an edge
      if (fall && s_q.shaped_valid && (new_b != s_q.shaped_b)) begin
        s_d.delay_busy = 1'b1;
        s_d.delay_cnt  = 11'h000;
        // a changing together with b gives an arbitrary but stable sample
        s_d.pend_a = new_a;
        s_d.pend_b = new_b;
      end else if (s_q.delay_busy) begin
        if (s_q.delay_cnt == DELAY_LAST) begin
          s_d.delay_busy = 1'b0;
          s_d.edge_irq   = 1'b1;
          s_d.level_b    = s_q.pend_b;
          s_d.level_a    = s_q.pend_a;
          s_d.phase_flag = s_q.pend_a ^ s_q.pend_b;
        end else begin
          s_d.delay_cnt = s_q.delay_cnt + 11'h001;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // state register
  // --------------------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      s_q <= '{phase: spd_pkg::PH_LOW, count: `SPD_COUNT_RST, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign SAMPLE_CLOCK_OUT_A = s_q.clk_a;
  assign SAMPLE_CLOCK_OUT_B = s_q.clk_b;
  assign MATCH_IRQ          = s_q.match_irq;
  assign EDGE_IRQ           = s_q.edge_irq;
  assign LEVEL_A_FLAG       = s_q.level_a;
  assign LEVEL_B_FLAG       = s_q.level_b;
  assign PHASE_FLAG         = s_q.phase_flag;
  assign COUNT_VALUE        = s_q.count;

endmodule : sampling_phase_detector
`default_nettype wire
